/* File: design/flash_status_pkg.sv */
// Constants, opcodes and carrier types for the status and write-control logic
// Function
// - Status read shifts bit 7 first on falls
// - Status bits repeat while clocks keep coming
// - Status read works during any internal write
// - Status write is opcode plus one byte
// - Status write changes only bits 2-5, 7
// - Protection and lock bits kept nonvolatile; here sys_rst clears them to NV_RESET
// - Status write needs write latch set first
// - Lock bit with low pin blocks status write
// - Busy bit high during internal write
// - Latch clear refuses all erase and writes
// - Write enable opcode sets the latch
// - Write disable opcode clears the latch
// - Latch clears at reset and write completion
// - Rejected writes and reads keep the latch
// - Top mode protects upper eighth, quarter, half
// - Bottom mode protects lower eighth, quarter, half
// - Zero select bits leave array unprotected
// - Power-down blocks commands, ignored while busy
// - Exit opcode byte leaves power-down
// - Small erase is opcode plus 24-bit address
// - Erase starts at select release, timer ends
// - Partial bytes or extra bytes discard writes
package flash_status_pkg;

    // Opcodes
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_WRITE_EN     = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
    localparam logic [7:0] OP_POWER_DOWN   = 8'hB9;
    localparam logic [7:0] OP_PD_EXIT      = 8'hAB;
    localparam logic [7:0] OP_SMALL_ERASE  = 8'h20;
    localparam logic [7:0] OP_SMALL_ERASE2 = 8'hD7;

    // Command lengths in bytes
    localparam logic [2:0] LEN_SINGLE      = 3'h1;
    localparam logic [2:0] LEN_STATUS_WR   = 3'h2;
    localparam logic [2:0] LEN_ERASE       = 3'h4;
    localparam logic [2:0] LEN_SATURATE    = 3'h5;

    // Address field of a small sector
    localparam int SECTOR_MSB = 18;
    localparam int SECTOR_LSB = 12;

    // Sector index boundaries of the protected regions
    localparam logic [6:0] SECT_TOP_EIGHTH   = 7'h70;
    localparam logic [6:0] SECT_TOP_QUARTER  = 7'h60;
    localparam logic [6:0] SECT_TOP_HALF     = 7'h40;
    localparam logic [6:0] SECT_BOT_EIGHTH   = 7'h10;
    localparam logic [6:0] SECT_BOT_QUARTER  = 7'h20;
    localparam logic [6:0] SECT_BOT_HALF     = 7'h40;

    // Timing
    localparam int CLOCK_PERIOD_NS     = 25;
    localparam int SMALL_ERASE_TIME_MS = 40;
    localparam int SMALL_ERASE_CYCLES  = SMALL_ERASE_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
    localparam int STATUS_WR_TIME_US   = 5;
    localparam int STATUS_WR_CYCLES    = STATUS_WR_TIME_US * 1000 / CLOCK_PERIOD_NS;
    localparam int TIMER_W             = 21;

    // Status word layout, bit 7 down to bit 0
    typedef struct packed {
        logic       status_lock;
        logic       reserved;
        logic       protect_top_bottom;
        logic       protect_sel_2;
        logic       protect_sel_1;
        logic       protect_sel_0;
        logic       write_latch;
        logic       busy;
    } status_word_s;

    // Nonvolatile part of the status word
    typedef struct packed {
        logic       status_lock;
        logic       protect_top_bottom;
        logic [2:0] protect_sel;
    } nv_bits_s;

    localparam nv_bits_s NV_RESET = 5'h00;

    // Internal write sequencer
    typedef enum logic [1:0] {
        WR_IDLE   = 2'b00,
        WR_STATUS = 2'b01,
        WR_ERASE  = 2'b11
    } write_state_e;

endpackage : flash_status_pkg

/* File: design/protect_decode.sv */
// Protection level decode for one small sector index
`timescale 1ns/1ps
`default_nettype none
module protect_decode
    import flash_status_pkg::*;
(
    // Protection setting
    input  wire nv_bits_s   nv,
    // Sector under test
    input  wire logic [6:0] sector,
    // Result
    output logic            is_protected
);

    logic       whole;
    logic       top_hit;
    logic       bot_hit;
    logic [1:0] level;

    assign level = nv.protect_sel[1:0];

    // Select bit 2 in top mode, or in bottom mode without a level, covers everything
    assign whole = (nv.protect_sel[2] && !nv.protect_top_bottom)
                 || (nv.protect_sel[2] && nv.protect_top_bottom && level == 2'h0);

    // Upper regions end at the top address
    assign top_hit = !nv.protect_top_bottom && !nv.protect_sel[2] &&
                     ((level == 2'h1 && sector >= SECT_TOP_EIGHTH) ||
                      (level == 2'h2 && sector >= SECT_TOP_QUARTER) ||
                      (level == 2'h3 && sector >= SECT_TOP_HALF));

    // Lower regions start at address zero
    assign bot_hit = nv.protect_top_bottom &&
                     ((level == 2'h1 && sector < SECT_BOT_EIGHTH) ||
                      (level == 2'h2 && sector < SECT_BOT_QUARTER) ||
                      (level == 2'h3 && sector < SECT_BOT_HALF));

    // All-zero select leaves nothing protected
    assign is_protected = whole || top_hit || bot_hit;

endmodule : protect_decode
`default_nettype wire

/* File: design/spi_flash_status_write_control.sv */
// Serial flash status register, write latch, power-down and small erase control
`timescale 1ns/1ps
`default_nettype none
module spi_flash_status_write_control
    import flash_status_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = SMALL_ERASE_CYCLES
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // Serial bus pins
    input  wire logic         cs_n,
    input  wire logic         sck,
    input  wire logic         si,
    input  wire logic         write_protect_n,
    output logic              so,
    output logic              so_oe_n,
    // Other write engines of the device
    input  wire logic         ext_busy,
    input  wire logic         ext_write_done,
    // Erase array control and state
    output logic              erase_start,
    output logic [6:0]        erase_sector,
    output logic              erase_done,
    output logic              power_down,
    output status_word_s      status_out
);

    // Registers
    logic         sck_prev_reg;
    logic         cs_prev_reg;
    logic [2:0]   bit_cnt_reg;
    logic [2:0]   byte_cnt_reg;
    logic [7:0]   shift_reg;
    logic [7:0]   opcode_reg;
    logic [23:0]  addr_reg;
    logic         rd_active_reg;
    logic [2:0]   out_idx_reg;
    logic         so_reg;
    logic         so_oe_n_reg;
    logic         wen_reg;
    logic         pd_reg;
    nv_bits_s     nv_reg;
    nv_bits_s     pend_reg;
    write_state_e state_reg;
    write_state_e state_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [6:0]   sector_reg;
    logic         erase_start_reg;
    logic         erase_done_reg;
    status_word_s status_reg;

    // Combinational nets
    logic         sck_rise;
    logic         sck_fall;
    logic         cs_rise;
    logic         cs_fall;
    logic [7:0]   shift_in;
    logic         byte_done;
    logic         opcode_done;
    logic         whole_bytes;
    logic         busy_any;
    logic         lock_active;
    logic         cmd_end;
    logic         is_erase_op;
    logic [6:0]   cmd_sector;
    logic         sector_prot;
    logic         do_wen;
    logic         do_wdis;
    logic         do_srw;
    logic         do_erase;
    logic         do_pd;
    logic         pd_exit;
    logic         timer_zero;
    logic         srw_finish;
    logic         erase_finish;
    status_word_s status_now;
    logic [TIMER_W-1:0] erase_load;
    logic [TIMER_W-1:0] srw_load;

    // Pin edge detection, bus activity only while selected
    assign sck_rise = !cs_n && sck && !sck_prev_reg;
    assign sck_fall = !cs_n && !sck && sck_prev_reg;
    assign cs_rise  = cs_n && !cs_prev_reg;
    assign cs_fall  = !cs_n && cs_prev_reg;

    // Serial byte assembly, most significant bit first
    assign shift_in    = {shift_reg[6:0], si};
    assign byte_done   = sck_rise && (bit_cnt_reg == 3'h7);
    assign opcode_done = byte_done && (byte_cnt_reg == 3'h0);
    assign whole_bytes = (bit_cnt_reg == 3'h0);

    // Device state used by command acceptance
    assign busy_any    = (state_reg != WR_IDLE) || ext_busy;
    assign lock_active = nv_reg.status_lock && !write_protect_n;
    assign is_erase_op = (opcode_reg == OP_SMALL_ERASE) || (opcode_reg == OP_SMALL_ERASE2);
    assign cmd_sector  = addr_reg[SECTOR_MSB:SECTOR_LSB];

    // Commands act at select release on a byte boundary only; power-down exit acts at the last opcode rise
    assign cmd_end = cs_rise && whole_bytes && !pd_reg;

    assign do_wen  = cmd_end && (opcode_reg == OP_WRITE_EN)  && (byte_cnt_reg == LEN_SINGLE);
    assign do_wdis = cmd_end && (opcode_reg == OP_WRITE_DIS) && (byte_cnt_reg == LEN_SINGLE);
    assign do_srw  = cmd_end && (opcode_reg == OP_STATUS_WRITE) &&
                     (byte_cnt_reg == LEN_STATUS_WR) &&
                     wen_reg && !busy_any && !lock_active;
    assign do_erase = cmd_end && is_erase_op && (byte_cnt_reg == LEN_ERASE) &&
                      wen_reg && !busy_any && !sector_prot;
    assign do_pd   = cmd_end && (opcode_reg == OP_POWER_DOWN) &&
                     (byte_cnt_reg == LEN_SINGLE) && !busy_any;
    assign pd_exit = pd_reg && opcode_done && (shift_in == OP_PD_EXIT);

    // Internal write completion
    assign timer_zero   = (timer_reg == '0);
    assign srw_finish   = (state_reg == WR_STATUS) && timer_zero;
    assign erase_finish = (state_reg == WR_ERASE) && timer_zero;
    assign erase_load   = TIMER_W'(ERASE_CYCLES - 1);
    assign srw_load     = TIMER_W'(STATUS_WR_CYCLES - 1);

    // Live status word as seen by a read
    assign status_now = '{
        status_lock:        nv_reg.status_lock,
        reserved:           1'b0,
        protect_top_bottom: nv_reg.protect_top_bottom,
        protect_sel_2:      nv_reg.protect_sel[2],
        protect_sel_1:      nv_reg.protect_sel[1],
        protect_sel_0:      nv_reg.protect_sel[0],
        write_latch:        wen_reg,
        busy:               busy_any
    };

    // Protection check of the addressed small sector
    protect_decode u_protect (
        .nv           (nv_reg),
        .sector       (cmd_sector),
        .is_protected (sector_prot)
    );

    // Write sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WR_IDLE: begin
                if (do_srw) begin
                    state_next = WR_STATUS;
                end else if (do_erase) begin
                    state_next = WR_ERASE;
                end
            end
            WR_STATUS: begin
                if (timer_zero) begin
                    state_next = WR_IDLE;
                end
            end
            WR_ERASE: begin
                if (timer_zero) begin
                    state_next = WR_IDLE;
                end
            end
            default: begin
                state_next = WR_IDLE;
            end
        endcase
    end

    // Pin history for edge detection
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg  <= 1'b1;
        end else begin
            sck_prev_reg <= sck;
            cs_prev_reg  <= cs_n;
        end
    end

    // Bit and byte counters, restarted by select fall
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 3'h0;
        end else if (cs_fall) begin
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done && byte_cnt_reg != LEN_SATURATE) begin
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
        end
    end

    // Shift register, opcode and address capture
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg  <= 8'h00;
            opcode_reg <= 8'h00;
            addr_reg   <= 24'h000000;
        end else if (sck_rise) begin
            shift_reg <= shift_in;
            if (opcode_done) begin
                opcode_reg <= shift_in;
            end else if (byte_done) begin
                addr_reg <= {addr_reg[15:0], shift_in};
            end
        end
    end

    // Status read output, one bit per falling clock, wrapping
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_active_reg <= 1'b0;
            out_idx_reg   <= 3'h7;
            so_reg        <= 1'b0;
            so_oe_n_reg   <= 1'b1;
        end else if (cs_n) begin
            rd_active_reg <= 1'b0;
            so_oe_n_reg   <= 1'b1;
        end else if (opcode_done) begin
            rd_active_reg <= (shift_in == OP_STATUS_READ) && !pd_reg;
            out_idx_reg   <= 3'h7;
        end else if (sck_fall && rd_active_reg) begin
            so_reg      <= status_now[out_idx_reg];
            so_oe_n_reg <= 1'b0;
            out_idx_reg <= out_idx_reg - 3'h1;
        end
    end

    // Write latch: set command wins over any clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wen_reg <= 1'b0;
        end else if (do_wen) begin
            wen_reg <= 1'b1;
        end else if (do_wdis || srw_finish || erase_finish || ext_write_done) begin
            wen_reg <= 1'b0;
        end
    end

    // Power-down state
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pd_reg <= 1'b0;
        end else if (pd_exit) begin
            pd_reg <= 1'b0;
        end else if (do_pd) begin
            pd_reg <= 1'b1;
        end
    end

    // Nonvolatile protection bits and pending status write data
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            nv_reg   <= NV_RESET;
            pend_reg <= NV_RESET;
        end else begin
            if (do_srw) begin
                pend_reg <= {addr_reg[7], addr_reg[5:2]};
            end
            if (srw_finish) begin
                nv_reg <= pend_reg;
            end
        end
    end

    // Internal write timer and sequencer state
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= WR_IDLE;
            timer_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg == WR_IDLE && do_srw) begin
                timer_reg <= srw_load;
            end else if (state_reg == WR_IDLE && do_erase) begin
                timer_reg <= erase_load;
            end else if (!timer_zero) begin
                timer_reg <= timer_reg - TIMER_W'(1);
            end
        end
    end

    // Erase array handshake and status mirror
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sector_reg      <= 7'h00;
            erase_start_reg <= 1'b0;
            erase_done_reg  <= 1'b0;
            status_reg      <= '0;
        end else begin
            erase_start_reg <= do_erase && state_reg == WR_IDLE;
            erase_done_reg  <= erase_finish;
            status_reg      <= status_now;
            if (do_erase) begin
                sector_reg <= cmd_sector;
            end
        end
    end

    // Outputs straight from registers
    assign so           = so_reg;
    assign so_oe_n      = so_oe_n_reg;
    assign erase_start  = erase_start_reg;
    assign erase_sector = sector_reg;
    assign erase_done   = erase_done_reg;
    assign power_down   = pd_reg;
    assign status_out   = status_reg;

endmodule : spi_flash_status_write_control
`default_nettype wire

/* File: test/status_write_checker_assertions.sv */
// Port-level checks for the status and write-control block
`timescale 1ns/1ps
`default_nettype none
module status_write_checker
    import flash_status_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = 50
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // Pins and side inputs
    input  wire logic         cs_n,
    input  wire logic         so_oe_n,
    input  wire logic         ext_busy,
    input  wire logic         ext_write_done,
    // Outputs under watch
    input  wire logic         erase_start,
    input  wire logic         erase_done,
    input  wire logic         power_down,
    input  wire status_word_s status_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Cycles since the last erase launch
    logic [31:0] since_start_reg;
    logic [31:0] since_start_next;
    assign since_start_next = erase_start ? 32'h0 : since_start_reg + 32'h1;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            since_start_reg <= '0;
        end else begin
            since_start_reg <= since_start_next;
        end
    end

    // Multi-step pieces of an erase
    sequence s_launch;
        erase_start ##1 !erase_start;
    endsequence
    sequence s_busy_run;
        status_out.busy [*8];
    endsequence

    property p_start_cause;
        erase_start |-> cs_n && $past(cs_n) && !power_down && status_out.write_latch;
    endproperty
    property p_start_busy;
        erase_start |-> s_launch ##1 s_busy_run;
    endproperty
    property p_done_time;
        erase_done |-> (since_start_reg + 32'h3 >= ERASE_CYCLES) && (since_start_reg <= ERASE_CYCLES + 2);
    endproperty
    property p_done_clears;
        erase_done |-> ##[1:2] (!status_out.write_latch && !status_out.busy);
    endproperty
    property p_oe_release;
        cs_n [*2] |=> so_oe_n;
    endproperty
    property p_reserved;
        !status_out.reserved;
    endproperty
    property p_ext_busy;
        ext_busy [*3] |-> status_out.busy;
    endproperty
    property p_ext_done;
        ext_write_done && cs_n ##1 cs_n |-> ##[1:2] !status_out.write_latch;
    endproperty
    property p_pd_entry;
        $rose(power_down) |-> cs_n && !status_out.busy;
    endproperty
    property p_pd_quiet;
        power_down |-> so_oe_n && !erase_start;
    endproperty

    a_start_cause: assert property (p_start_cause) else $error("erase launched without cause");
    a_start_busy: assert property (p_start_busy) else $error("erase launch without busy run");
    a_done_time: assert property (p_done_time) else $error("erase length wrong");
    a_done_clears: assert property (p_done_clears) else $error("latch or busy kept after erase");
    a_oe_release: assert property (p_oe_release) else $error("output enabled while deselected");
    a_reserved: assert property (p_reserved) else $error("reserved status bit set");
    a_ext_busy: assert property (p_ext_busy) else $error("external busy not shown");
    a_ext_done: assert property (p_ext_done) else $error("latch kept after write done");
    a_pd_entry: assert property (p_pd_entry) else $error("power-down entered while busy");
    a_pd_quiet: assert property (p_pd_quiet) else $error("activity in power-down");
endmodule : status_write_checker

bind spi_flash_status_write_control status_write_checker #(.ERASE_CYCLES(ERASE_CYCLES)) i_chk (
    .clock(clock), .sys_rst(sys_rst), .cs_n(cs_n), .so_oe_n(so_oe_n), .ext_busy(ext_busy),
    .ext_write_done(ext_write_done), .erase_start(erase_start), .erase_done(erase_done),
    .power_down(power_down), .status_out(status_out));
`default_nettype wire

/* File: test/spi_host_model.sv */
// Serial bus host model: frames commands and captures returned bits
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // System clock
    input  wire logic        clock,
    // Bus pins
    output logic             cs_n,
    output logic             sck,
    output logic             si,
    input  wire logic        so,
    input  wire logic        so_oe_n
);
    logic [15:0] rx_bits;
    event        rx_done;

    // Idle bus: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rx_bits = '0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : hold

    // Frame: select, send bits MSB first on rises, read on falls, release
    task automatic xfer(input logic [31:0] tx, input int nbits, input int rbits);
        rx_bits = '0;
        cs_n = 1'b0;
        hold(2);
        for (int i = 0; i < nbits; i++) begin
            si = tx[31 - i];
            hold(2);
            sck = 1'b1;
            hold(2);
            sck = 1'b0;
        end
        for (int i = 0; i < rbits; i++) begin
            hold(2);
            rx_bits = {rx_bits[14:0], so_oe_n ? 1'bx : so};
            sck = 1'b1;
            hold(2);
            sck = 1'b0;
        end
        hold(2);
        cs_n = 1'b1;
        si = ~si;
        if (rbits > 0) begin
            -> rx_done;
        end
        hold(6);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the status and write-control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import flash_status_pkg::*;
    localparam int ERASE_N     = 50;
    localparam int CYCLE_LIMIT = 40000;

    logic         clock;
    logic         sys_rst;
    logic         cs_n;
    logic         sck;
    logic         si;
    logic         write_protect_n;
    logic         so;
    logic         so_oe_n;
    logic         ext_busy;
    logic         ext_write_done;
    logic         erase_start;
    logic [6:0]   erase_sector;
    logic         erase_done;
    logic         power_down;
    status_word_s status_out;
    logic         start_seen;
    logic [31:0]  rnd;
    logic [15:0]  exp_q[$];
    int           error_cnt = 0;
    int           checks_done = 0;
    int           cycle_cnt = 0;

    spi_flash_status_write_control #(.ERASE_CYCLES(ERASE_N)) i_spi_flash_status_write_control (
        .clock(clock), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si),
        .write_protect_n(write_protect_n), .so(so), .so_oe_n(so_oe_n), .ext_busy(ext_busy),
        .ext_write_done(ext_write_done), .erase_start(erase_start), .erase_sector(erase_sector),
        .erase_done(erase_done), .power_down(power_down), .status_out(status_out));

    spi_host_model host (
        .clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));

    // Clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("Counts: checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // Command helpers; reads note their expectation first
    task automatic cmd(input logic [7:0] op);
        host.xfer({op, 24'h0}, 8, 0);
    endtask : cmd
    task automatic wsr(input logic [7:0] d);
        host.xfer({OP_STATUS_WRITE, d, 16'h0}, 16, 0);
    endtask : wsr
    task automatic rd_status(input logic [7:0] exp, input int n);
        exp_q.push_back((n == 16) ? {exp, exp} : {8'h00, exp});
        host.xfer({OP_STATUS_READ, 24'h0}, 8, n);
    endtask : rd_status

    // Set protection, try one erase, check launch and final status
    task automatic erase_case(input logic [7:0] sr, input logic [7:0] op,
                              input logic [23:0] addr, input logic acc);
        cmd(OP_WRITE_EN);
        wsr(sr);
        tick(220);
        cmd(OP_WRITE_EN);
        start_seen = 1'b0;
        host.xfer({op, addr}, 32, 0);
        check("erase_start", {15'h0, acc}, {15'h0, start_seen});
        if (acc) check("erase_sector", {9'h0, addr[18:12]}, {9'h0, erase_sector});
        tick(ERASE_N + 20);
        rd_status(acc ? (sr & 8'hBC) : ((sr & 8'hBC) | 8'h02), 8);
    endtask : erase_case

    // Result watcher: compares each status read with the oldest note
    initial begin
        forever begin
            @(host.rx_done);
            check("status_read", exp_q.pop_front(), host.rx_bits);
        end
    end

    // Launch catcher and hang guard
    always @(posedge clock) begin
        if (erase_start) start_seen <= 1'b1;
        cycle_cnt++;
        if (cycle_cnt == CYCLE_LIMIT) begin
            error_cnt++;
            $display("[FAIL] run_length expected %0d seen more", CYCLE_LIMIT);
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        write_protect_n = 1'b1;
        ext_busy = 1'b0;
        ext_write_done = 1'b0;
        start_seen = 1'b0;
        rnd = $urandom(97253);
        tick(8);
        sys_rst = 1'b0;
        tick(2);
        rd_status(8'h00, 16);
        cmd(OP_WRITE_EN);
        rd_status(8'h02, 16);
        cmd(OP_WRITE_DIS);
        rd_status(8'h00, 8);
        wsr(8'h3C);
        rd_status(8'h00, 8);
        $display("test finished: latch");
        rnd = $urandom;
        cmd(OP_WRITE_EN);
        wsr(rnd[7:0]);
        rd_status(8'h03, 8);
        tick(220);
        rd_status(rnd[7:0] & 8'hBC, 8);
        cmd(OP_WRITE_EN);
        wsr(8'h80);
        tick(220);
        write_protect_n = 1'b0;
        cmd(OP_WRITE_EN);
        wsr(8'h00);
        tick(220);
        rd_status(8'h82, 8);
        write_protect_n = 1'b1;
        wsr(8'h00);
        tick(220);
        rd_status(8'h00, 8);
        cmd(OP_WRITE_EN);
        host.xfer({OP_STATUS_WRITE, 8'h1C, 8'h1C, 8'h00}, 24, 0);
        rd_status(8'h02, 8);
        host.xfer({OP_STATUS_WRITE, 8'h1C, 16'h0}, 12, 0);
        rd_status(8'h02, 8);
        $display("test finished: status write");
        erase_case(8'h04, OP_SMALL_ERASE, 24'h070000, 1'b0);
        erase_case(8'h04, OP_SMALL_ERASE2, 24'h06F000, 1'b1);
        erase_case(8'h08, OP_SMALL_ERASE, 24'h060000, 1'b0);
        erase_case(8'h0C, OP_SMALL_ERASE, 24'h040000, 1'b0);
        erase_case(8'h0C, OP_SMALL_ERASE2, 24'h03F000, 1'b1);
        erase_case(8'h24, OP_SMALL_ERASE, 24'h00F000, 1'b0);
        erase_case(8'h24, OP_SMALL_ERASE, 24'h010000, 1'b1);
        erase_case(8'h28, OP_SMALL_ERASE, 24'h01F000, 1'b0);
        erase_case(8'h2C, OP_SMALL_ERASE2, 24'h03FFFF, 1'b0);
        erase_case(8'h2C, OP_SMALL_ERASE, 24'h040000, 1'b1);
        erase_case(8'h10, OP_SMALL_ERASE, 24'h07F000, 1'b0);
        erase_case(8'h20, OP_SMALL_ERASE2, 24'hF81000, 1'b1);
        $display("test finished: erase");
        cmd(OP_POWER_DOWN);
        check("power_down", 16'h1, {15'h0, power_down});
        rd_status(8'hXX, 8);
        cmd(OP_WRITE_EN);
        cmd(OP_PD_EXIT);
        check("power_down", 16'h0, {15'h0, power_down});
        rd_status(8'h20, 8);
        cmd(OP_WRITE_EN);
        wsr(8'h00);
        cmd(OP_POWER_DOWN);
        check("power_down", 16'h0, {15'h0, power_down});
        tick(220);
        $display("test finished: power-down");
        ext_busy = 1'b1;
        rd_status(8'h01, 8);
        ext_busy = 1'b0;
        cmd(OP_WRITE_EN);
        ext_write_done = 1'b1;
        tick(1);
        ext_write_done = 1'b0;
        tick(3);
        rd_status(8'h00, 8);
        $display("test finished: side engines");
        tick(4);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
